// *** atc_pkg.sv ***
// Constants, field layouts and carrier types of the async 8-bit timer control block
// ==========================================================================
// Notes on behaviour
// - Writing force_compare_a one applies the compare-output action at once; it is a strobe.
// - A forced compare raises no flag and never clears the counter.
// - Force works only in non-PWM modes, reads zero; bits 6:3 read zero.
// - clock_source_select: 0 stop, 1 undivided, 2..7 divide 8/32/64/128/256/1024.
// - counter_value is read/write by software and resets to zero.
// - A counter write suppresses the compare match on the next timer clock.
// - compare_a_value is compared continuously; a match sets the flag and drives output.
// - External clock enabled plus async mode enables the input buffer; async mode without it runs the oscillator.
// - Async select zero runs from the bus clock; one runs from the crystal pin.
// - Changing async select guarantees none of counter, compare or control A.
// - Async select stays one only when the system clock comes from an RC oscillator.
// - Async writes to counter, compare, control A or B set that busy flag until loaded.
// - In async mode counter reads live; compare and controls read their temporary copies.
// - Mask bit 1 enables compare, bit 0 overflow; request needs enable, flag, global bit.
// - compare_a_flag sets on match; clears on vector taken or written one.
// - overflow_flag sets on overflow; clears on vector taken or written one.
// - In phase-correct PWM overflow_flag sets when counting turns at bottom.
// - Non-PWM compare-output codes: 00 off, 01 toggle, 10 clear, 11 set.
// - Modes 0 normal and 2 clear-on-compare are non-PWM; 1 phase-correct, 3 fast PWM.
package atc_pkg;
   // ==========================================================================
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTRL_A = 10'h025;
   localparam logic [9:0] IDX_CTRL_B = 10'h026;
   localparam logic [9:0] IDX_COUNTER = 10'h027;
   localparam logic [9:0] IDX_COMPARE_A = 10'h028;
   localparam logic [9:0] IDX_ASYNC_STATUS = 10'h029;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h02A;
   localparam logic [9:0] IDX_IRQ_FLAGS = 10'h02B;
   // ==========================================================================
   // Field positions and reset values
   localparam int B_FORCE = 7;
   localparam int B_EXT_CLK = 6;
   localparam int B_ASYNC = 5;
   localparam int B_CNT_BUSY = 4;
   localparam int B_CMP_BUSY = 3;
   localparam int B_CTA_BUSY = 1;
   localparam int B_CTB_BUSY = 0;
   localparam int B_CMP_A = 1;
   localparam int B_OVF = 0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================================
   // Prescaler taps
   localparam int PRE_W = 10;
   localparam int DIV_8 = 8;
   localparam int DIV_32 = 32;
   localparam int DIV_64 = 64;
   localparam int DIV_128 = 128;
   localparam int DIV_256 = 256;
   localparam int DIV_1024 = 1024;
   // ==========================================================================
   // Modes and carriers
   typedef enum logic [1:0] {
      WGM_NORMAL = 2'b00,
      WGM_PHASE = 2'b01,
      WGM_CTC = 2'b10,
      WGM_FAST = 2'b11
   } atc_wgm_t;
   typedef enum logic [1:0] {
      COM_OFF = 2'b00,
      COM_TOGGLE = 2'b01,
      COM_CLEAR = 2'b10,
      COM_SET = 2'b11
   } atc_com_t;
   typedef struct packed {
      atc_com_t com;
      logic [3:0] rsvd;
      atc_wgm_t wgm;
   } atc_ctrl_a_t;
   typedef struct packed {
      logic force_cmp;
      logic [3:0] rsvd;
      logic [2:0] cs;
   } atc_ctrl_b_t;
   typedef struct packed {
      logic counter;
      logic compare_a;
      logic control_a;
      logic control_b;
   } atc_busy_t;
endpackage : atc_pkg

// *** atc_timer.sv ***
// Bus-facing control, prescaler, counter and compare logic of the async 8-bit timer
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module atc_timer
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic crystal_input_pin,
   input wire logic sysclk_from_rc_osc,
   input wire logic global_irq_enable,
   input wire logic compare_a_vector_taken,
   input wire logic overflow_vector_taken,
   output logic compare_a_output,
   output logic compare_a_output_en,
   output logic ext_clock_buffer_en,
   output logic crystal_osc_en,
   output logic compare_a_irq_req,
   output logic overflow_irq_req
);
   import atc_pkg::*;

   // ==========================================================================
   // Helpers
   function automatic logic [PRE_W-1:0] tap_mask(input logic [2:0] cs);
      case (cs)
         3'h2: tap_mask = PRE_W'(DIV_8 - 1);
         3'h3: tap_mask = PRE_W'(DIV_32 - 1);
         3'h4: tap_mask = PRE_W'(DIV_64 - 1);
         3'h5: tap_mask = PRE_W'(DIV_128 - 1);
         3'h6: tap_mask = PRE_W'(DIV_256 - 1);
         3'h7: tap_mask = PRE_W'(DIV_1024 - 1);
         default: tap_mask = '0;
      endcase
   endfunction : tap_mask

   function automatic logic com_action(input atc_com_t com, input logic cur);
      case (com)
         COM_TOGGLE: com_action = ~cur;
         COM_CLEAR: com_action = 1'b0;
         COM_SET: com_action = 1'b1;
         default: com_action = cur;
      endcase
   endfunction : com_action

   // ==========================================================================
   // Bus slave: write path
   logic aw_have_q, w_have_q;
   logic [9:0] waddr_q;
   logic [7:0] wbyte_q;
   logic wlane_q;
   logic do_write;
   logic w_hit;

   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= '0;
         wbyte_q <= RESET_BYTE;
         wlane_q <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            waddr_q <= s_axi_awaddr[11:2];
         end
         else if (do_write)
            aw_have_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
         end
         else if (do_write)
            w_have_q <= 1'b0;
      end
   end

   assign w_hit = (waddr_q >= IDX_CTRL_A) && (waddr_q <= IDX_IRQ_FLAGS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Strobes for one-byte register writes
   logic wr_cta, wr_ctb, wr_cnt, wr_cmp, wr_asy, wr_msk, wr_flg;
   assign wr_cta = do_write && wlane_q && (waddr_q == IDX_CTRL_A);
   assign wr_ctb = do_write && wlane_q && (waddr_q == IDX_CTRL_B);
   assign wr_cnt = do_write && wlane_q && (waddr_q == IDX_COUNTER);
   assign wr_cmp = do_write && wlane_q && (waddr_q == IDX_COMPARE_A);
   assign wr_asy = do_write && wlane_q && (waddr_q == IDX_ASYNC_STATUS);
   assign wr_msk = do_write && wlane_q && (waddr_q == IDX_IRQ_MASK);
   assign wr_flg = do_write && wlane_q && (waddr_q == IDX_IRQ_FLAGS);

   // ==========================================================================
   // Clock source and async status
   logic async_q, ext_clk_q, xtal_d_q;
   logic xtal_edge, src_tick, timer_tick;
   logic [PRE_W-1:0] pre_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         async_q <= 1'b0;
         ext_clk_q <= 1'b0;
      end
      else if (wr_asy)
      begin
         ext_clk_q <= wbyte_q[B_EXT_CLK];
         // Switching leaves counter, compare and control A as they stand
         async_q <= wbyte_q[B_ASYNC] && sysclk_from_rc_osc;
      end
      else
         async_q <= async_q && sysclk_from_rc_osc;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         xtal_d_q <= 1'b0;
         ext_clock_buffer_en <= 1'b0;
         crystal_osc_en <= 1'b0;
      end
      else
      begin
         xtal_d_q <= crystal_input_pin;
         ext_clock_buffer_en <= ext_clk_q && async_q;
         crystal_osc_en <= async_q && !ext_clk_q;
      end
   end

   // Crystal and external clock both arrive on the same pin here
   assign xtal_edge = crystal_input_pin && !xtal_d_q;
   assign src_tick = async_q ? xtal_edge : 1'b1;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pre_q <= '0;
      else if (src_tick)
         pre_q <= pre_q + 1'b1;
   end

   // ==========================================================================
   // Temporary copies and live registers
   atc_ctrl_a_t cta_tmp_q, cta_q;
   atc_ctrl_b_t ctb_tmp_q, ctb_q;
   logic [7:0] cmp_tmp_q, cmp_q, cnt_tmp_q;
   atc_busy_t busy_q;
   logic ld_cta, ld_ctb, ld_cmp, ld_cnt;

   // Busy copies load on the next crystal edge, which acts as acknowledge
   assign ld_cta = async_q ? (busy_q.control_a && xtal_edge) : wr_cta;
   assign ld_ctb = async_q ? (busy_q.control_b && xtal_edge) : wr_ctb;
   assign ld_cmp = async_q ? (busy_q.compare_a && xtal_edge) : wr_cmp;
   assign ld_cnt = async_q ? (busy_q.counter && xtal_edge) : wr_cnt;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cta_tmp_q <= '0;
         ctb_tmp_q <= '0;
         cmp_tmp_q <= RESET_BYTE;
         cnt_tmp_q <= RESET_BYTE;
      end
      else
      begin
         if (wr_cta)
            cta_tmp_q <= atc_ctrl_a_t'({wbyte_q[7:6], 4'h0, wbyte_q[1:0]});
         if (wr_ctb)
            ctb_tmp_q <= atc_ctrl_b_t'({wbyte_q[B_FORCE], 4'h0, wbyte_q[2:0]});
         if (wr_cmp)
            cmp_tmp_q <= wbyte_q;
         if (wr_cnt)
            cnt_tmp_q <= wbyte_q;
      end
   end

   // A write while busy reloads the copy; the value may tear, as warned
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         busy_q <= '0;
      else
      begin
         busy_q.counter <= async_q && (wr_cnt || (busy_q.counter && !xtal_edge));
         busy_q.compare_a <= async_q && (wr_cmp || (busy_q.compare_a && !xtal_edge));
         busy_q.control_a <= async_q && (wr_cta || (busy_q.control_a && !xtal_edge));
         busy_q.control_b <= async_q && (wr_ctb || (busy_q.control_b && !xtal_edge));
      end
   end

   // Sync mode takes the bus byte, async mode the held copy
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cta_q <= '0;
         ctb_q <= '0;
         cmp_q <= RESET_BYTE;
      end
      else
      begin
         if (ld_cta)
            cta_q <= async_q ? cta_tmp_q :
               atc_ctrl_a_t'({wbyte_q[7:6], 4'h0, wbyte_q[1:0]});
         if (ld_ctb)
            ctb_q <= async_q ? ctb_tmp_q :
               atc_ctrl_b_t'({wbyte_q[B_FORCE], 4'h0, wbyte_q[2:0]});
         if (ld_cmp)
            cmp_q <= async_q ? cmp_tmp_q : wbyte_q;
      end
   end

   // ==========================================================================
   // Counter, direction and compare
   logic [7:0] cnt_q, cnt_next;
   logic down_q, block_q, hit, ovf, force_now, non_pwm;

   assign timer_tick = src_tick && (ctb_q.cs != 3'h0)
      && ((pre_q & tap_mask(ctb_q.cs)) == tap_mask(ctb_q.cs));
   assign non_pwm = (cta_q.wgm == WGM_NORMAL) || (cta_q.wgm == WGM_CTC);
   assign hit = timer_tick && (cnt_q == cmp_q) && !block_q;
   assign force_now = ld_ctb && non_pwm
      && (async_q ? ctb_tmp_q.force_cmp : wbyte_q[B_FORCE]);

   always_comb
   begin
      case (cta_q.wgm)
         WGM_CTC: cnt_next = hit ? CNT_BOTTOM : cnt_q + 8'h01;
         WGM_PHASE:
            if (down_q)
               cnt_next = (cnt_q == CNT_BOTTOM) ? cnt_q + 8'h01 : cnt_q - 8'h01;
            else
               cnt_next = (cnt_q == CNT_MAX) ? cnt_q - 8'h01 : cnt_q + 8'h01;
         default: cnt_next = cnt_q + 8'h01;
      endcase
   end

   assign ovf = timer_tick && ((cta_q.wgm == WGM_PHASE) ?
      (down_q && cnt_q == CNT_BOTTOM) : (cnt_q == CNT_MAX));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= RESET_BYTE;
         down_q <= 1'b0;
      end
      else if (ld_cnt)
         cnt_q <= async_q ? cnt_tmp_q : wbyte_q;
      else if (timer_tick)
      begin
         cnt_q <= cnt_next;
         if (cta_q.wgm != WGM_PHASE)
            down_q <= 1'b0;
         else if (cnt_q == CNT_MAX)
            down_q <= 1'b1;
         else if (cnt_q == CNT_BOTTOM)
            down_q <= 1'b0;
      end
   end

   // Blocks the match on the first timer clock after a counter load
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         block_q <= 1'b0;
      else if (ld_cnt)
         block_q <= 1'b1;
      else if (timer_tick)
         block_q <= 1'b0;
   end

   // ==========================================================================
   // Waveform output
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         compare_a_output <= 1'b0;
         compare_a_output_en <= 1'b0;
      end
      else
      begin
         compare_a_output_en <= (cta_q.com != COM_OFF);
         if (non_pwm)
         begin
            if (hit || force_now)
               compare_a_output <= com_action(cta_q.com, compare_a_output);
         end
         else if (cta_q.com[1])
         begin
            // Mode bit 0 picks set or clear; PWM force is ignored
            if (hit)
               compare_a_output <= cta_q.com[0] ^ (cta_q.wgm == WGM_PHASE && down_q);
            else if (cta_q.wgm == WGM_FAST && timer_tick && cnt_q == CNT_MAX)
               compare_a_output <= !cta_q.com[0];
         end
      end
   end

   // ==========================================================================
   // Flags, mask and requests
   logic [1:0] mask_q, flag_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_q <= 2'h0;
      else if (wr_msk)
         mask_q <= wbyte_q[1:0];
   end

   // Hardware set wins over a same-cycle clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flag_q <= 2'h0;
      else
      begin
         flag_q[B_CMP_A] <= hit || (flag_q[B_CMP_A] && !compare_a_vector_taken
            && !(wr_flg && wbyte_q[B_CMP_A]));
         flag_q[B_OVF] <= ovf || (flag_q[B_OVF] && !overflow_vector_taken
            && !(wr_flg && wbyte_q[B_OVF]));
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         compare_a_irq_req <= 1'b0;
         overflow_irq_req <= 1'b0;
      end
      else
      begin
         compare_a_irq_req <= flag_q[B_CMP_A] && mask_q[B_CMP_A] && global_irq_enable;
         overflow_irq_req <= flag_q[B_OVF] && mask_q[B_OVF] && global_irq_enable;
      end
   end

   // ==========================================================================
   // Bus slave: read path
   logic [7:0] rd_byte;
   logic rd_hit;

   always_comb
   begin
      rd_hit = 1'b1;
      case (s_axi_araddr[11:2])
         IDX_CTRL_A: rd_byte = cta_tmp_q;
         IDX_CTRL_B: rd_byte = {5'h00, ctb_tmp_q.cs};
         IDX_COUNTER: rd_byte = cnt_q;
         IDX_COMPARE_A: rd_byte = cmp_tmp_q;
         IDX_ASYNC_STATUS: rd_byte = {1'b0, ext_clk_q, async_q, busy_q.counter,
            busy_q.compare_a, 1'b0, busy_q.control_a, busy_q.control_b};
         IDX_IRQ_MASK: rd_byte = {6'h00, mask_q};
         IDX_IRQ_FLAGS: rd_byte = {6'h00, flag_q};
         default:
         begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule : atc_timer
`default_nettype wire

// *** atc_timer_monitor.sv ***
// Port-level checks for the async 8-bit timer control block
`timescale 1ns/10ps
`default_nettype none
module atc_timer_monitor
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic global_irq_enable,
   input wire logic compare_a_irq_req,
   input wire logic overflow_irq_req,
   input wire logic ext_clock_buffer_en,
   input wire logic crystal_osc_en
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==========
   // Bus answers
   chk_b_stands:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   chk_r_stands:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   chk_rdata_byte:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data above the byte not zero");
   chk_ar_refused:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   chk_rd_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_wr_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         && !s_axi_bvalid |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   // ==========
   // Interrupt gating and clock paths
   chk_cmp_gate:
      assert property (!global_irq_enable |=> !compare_a_irq_req)
      else $error("compare request without global enable");
   chk_ovf_gate:
      assert property (!global_irq_enable |=> !overflow_irq_req)
      else $error("overflow request without global enable");
   chk_clk_paths:
      assert property (!(ext_clock_buffer_en && crystal_osc_en))
      else $error("oscillator and input buffer both on");
endmodule : atc_timer_monitor
`default_nettype wire

// *** test_atc_timer.sv ***
// Self-checking testbench of the async 8-bit timer control block
`timescale 1ns/10ps
`default_nettype none
module test_atc_timer;
   import atc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic crystal_input_pin = 1'b0, sysclk_from_rc_osc = 1'b0, global_irq_enable = 1'b0;
   logic compare_a_vector_taken = 1'b0, overflow_vector_taken = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, got_resp;
   logic [31:0] s_axi_rdata, got_data;
   logic compare_a_output, compare_a_output_en, ext_clock_buffer_en, crystal_osc_en;
   logic compare_a_irq_req, overflow_irq_req;
   int err_total = 0, total_checks = 0;
   atc_timer u_dut (.*);
   always #5 aclk = ~aclk;
   // ==========
   // Bus and compare helpers
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   task automatic step(inout int n);
      @(posedge aclk);
      n++;
      if (n > 64)
      begin
         err_total++;
         $display("mismatch at %0t: handshake timed out", $time);
         test_done();
      end
   endtask : step
   task automatic wr(input logic [9:0] idx, input logic [7:0] val);
      int n;
      logic aw_ok, w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         step(n);
         if (s_axi_awvalid && s_axi_awready) aw_ok = 1'b1;
         if (s_axi_wvalid && s_axi_wready) w_ok = 1'b1;
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid) step(n);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      got_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [9:0] idx);
      int n;
      n = 0;
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      step(n);
      while (!s_axi_arready) step(n);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) step(n);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      got_data = s_axi_rdata;
      got_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
      rd(idx);
      cmp(got_data, exp, "register read");
   endtask : rdc
   // ==========
   // Scenarios
   task automatic t_reset_values;
      cmp({compare_a_output, compare_a_output_en, compare_a_irq_req}, 0, "outputs");
      for (int i = 0; i < 7; i++)
         rdc(IDX_CTRL_A + 10'(i), 32'h00000000);
      wr(10'h030, 8'hFF);
      cmp(got_resp, RESP_SLVERR, "unmapped write");
      rdc(10'h030, 32'h00000000);
      cmp(got_resp, RESP_SLVERR, "unmapped read");
   endtask : t_reset_values
   task automatic t_force;
      logic [7:0] ctl [5] = '{8'hC3, 8'hC2, 8'h82, 8'h42, 8'h42};
      logic [4:0] outs = 5'b01010;
      wr(IDX_COUNTER, 8'h33);
      for (int i = 0; i < 5; i++)
      begin
         wr(IDX_CTRL_A, ctl[i]);
         wr(IDX_CTRL_B, (i == 0) ? 8'h00 : 8'h80);
         cyc(2);
         cmp({compare_a_output_en, compare_a_output}, {1'b1, outs[i]}, "force");
      end
      rdc(IDX_CTRL_B, 32'h00000000);
      rdc(IDX_COUNTER, 32'h00000033);
      rdc(IDX_IRQ_FLAGS, 32'h00000000);
      wr(IDX_CTRL_B, 8'h7F);
      rdc(IDX_CTRL_B, 32'h00000007);
      wr(IDX_CTRL_B, 8'h00);
      wr(IDX_CTRL_A, 8'h00);
      cyc(2);
      cmp(compare_a_output_en, 1'b0, "output disconnected");
   endtask : t_force
   task automatic t_match;
      wr(IDX_COMPARE_A, 8'h40);
      wr(IDX_COUNTER, 8'h00);
      wr(IDX_IRQ_FLAGS, 8'h03);
      wr(IDX_CTRL_B, 8'h01);
      wr(IDX_COUNTER, 8'h40);
      cyc(20);
      wr(IDX_CTRL_B, 8'h00);
      rdc(IDX_IRQ_FLAGS, 32'h00000000);
      wr(IDX_IRQ_MASK, 8'h02);
      global_irq_enable <= 1'b1;
      wr(IDX_COMPARE_A, 8'h10);
      wr(IDX_COUNTER, 8'h00);
      wr(IDX_CTRL_B, 8'h01);
      cyc(30);
      wr(IDX_CTRL_B, 8'h00);
      rdc(IDX_IRQ_FLAGS, 32'h00000002);
      cmp(compare_a_irq_req, 1'b1, "compare request");
      global_irq_enable <= 1'b0;
      cyc(2);
      cmp(compare_a_irq_req, 1'b0, "request gated");
      global_irq_enable <= 1'b1;
      compare_a_vector_taken <= 1'b1;
      cyc(1);
      compare_a_vector_taken <= 1'b0;
      cyc(2);
      rdc(IDX_IRQ_FLAGS, 32'h00000000);
   endtask : t_match
   task automatic t_overflow;
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_COMPARE_A, 8'hC0);
      wr(IDX_COUNTER, 8'hF0);
      wr(IDX_CTRL_B, 8'h01);
      cyc(20);
      wr(IDX_CTRL_B, 8'h00);
      rdc(IDX_IRQ_FLAGS, 32'h00000001);
      cmp(overflow_irq_req, 1'b1, "overflow request");
      wr(IDX_IRQ_FLAGS, 8'h01);
      rdc(IDX_IRQ_FLAGS, 32'h00000000);
      wr(IDX_CTRL_A, 8'h01);
      wr(IDX_COUNTER, 8'hF0);
      wr(IDX_CTRL_B, 8'h01);
      cyc(100);
      cmp(overflow_irq_req, 1'b0, "no overflow at top");
      cyc(200);
      wr(IDX_CTRL_B, 8'h00);
      cmp(overflow_irq_req, 1'b1, "overflow at bottom");
      wr(IDX_CTRL_A, 8'h00);
   endtask : t_overflow
   task automatic t_prescale;
      int tap [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
      int lo;
      int hi;
      for (int c = 0; c < 8; c++)
      begin
         lo = (c == 0) ? 0 : 10;
         hi = (c == 0) ? 0 : ((c == 1) ? 16 : 11);
         wr(IDX_COUNTER, 8'h00);
         wr(IDX_CTRL_B, 8'(c));
         cyc((c == 0) ? 50 : 10 * tap[c]);
         wr(IDX_CTRL_B, 8'h00);
         rd(IDX_COUNTER);
         cmp({31'h0, got_data[7:0] inside {[lo:hi]}}, 32'h1, "tick count");
      end
   endtask : t_prescale
   task automatic t_async;
      wr(IDX_ASYNC_STATUS, 8'h40);
      wr(IDX_ASYNC_STATUS, 8'h60);
      rdc(IDX_ASYNC_STATUS, 32'h00000040);
      sysclk_from_rc_osc <= 1'b1;
      wr(IDX_ASYNC_STATUS, 8'h60);
      rdc(IDX_ASYNC_STATUS, 32'h00000060);
      cmp({ext_clock_buffer_en, crystal_osc_en}, 2'b10, "clock enables");
      wr(IDX_COMPARE_A, 8'h55);
      wr(IDX_COUNTER, 8'h12);
      wr(IDX_CTRL_A, 8'h00);
      wr(IDX_CTRL_B, 8'h00);
      rdc(IDX_ASYNC_STATUS, 32'h0000007B);
      rdc(IDX_COMPARE_A, 32'h00000055);
      crystal_input_pin <= 1'b1;
      cyc(3);
      crystal_input_pin <= 1'b0;
      cyc(3);
      rdc(IDX_ASYNC_STATUS, 32'h00000060);
      rdc(IDX_COUNTER, 32'h00000012);
      wr(IDX_ASYNC_STATUS, 8'h20);
      cyc(2);
      cmp({ext_clock_buffer_en, crystal_osc_en}, 2'b01, "oscillator path");
   endtask : t_async
   initial
   begin
      cyc(3);
      aresetn <= 1'b1;
      cyc(1);
      t_reset_values();
      t_force();
      t_match();
      t_overflow();
      t_prescale();
      t_async();
      test_done();
   end
endmodule : test_atc_timer
bind atc_timer atc_timer_monitor u_mon (.*);
`default_nettype wire
